// ===== logic/thw_regs.svh
`ifndef THW_REGS_SVH
`define THW_REGS_SVH
// Register indices; byte address is four times the index
`define THW_IDX_ENSEL    8'hE0
`define THW_IDX_BASE0    8'hE1
`define THW_IDX_BASE3    8'hE4
`define THW_IDX_DCNT     8'hE5
`define THW_IDX_RAWLAST  8'hE7
`define THW_IDX_CTRL     8'hE8
`define THW_IDX_SRC1     8'h49
`define THW_IDX_SRC2     8'h40
`define THW_IDX_RD1_INT  8'h50
`define THW_IDX_RD1_FRC  8'h51
`define THW_IDX_RD2_INT  8'h52
`define THW_IDX_RD2_FRC  8'h53
`define THW_IDX_IRQ_STS  8'h60
`define THW_IDX_IRQ_MSK  8'h61
// Field positions
`define THW_CTRL_RAW_BIT 3
`define THW_DCNT_MAX_BIT 1
// Reset values
`define THW_RST_BYTE     8'h00
`define THW_RST_CTRL     8'h03
// Link timing: clock in kHz and bit rates in kbps per speed code
`define THW_CLK_KHZ      20000
`define THW_KBPS_0       2
`define THW_KBPS_1       100
`define THW_KBPS_2       500
`define THW_KBPS_3       1000
`define THW_QTR(k)       (`THW_CLK_KHZ / (4 * (k)))
`define THW_GAP_QTRS     4'h8
// Frame contents
`define THW_ADDR_BASE    8'h30
`define THW_CMD_TEMP     8'h01
`define THW_WLEN_QUERY   8'h01
`define THW_RLEN_QUERY   8'h02
`define THW_CRC_POLY     8'h07
`define THW_BAD_LIMIT    2'h3
`endif

// ===== logic/thw_pkg.sv
package thw_pkg;
  typedef enum logic [1:0] {
    THW_S_IDLE = 2'b00,
    THW_S_LOAD = 2'b01,
    THW_S_XFER = 2'b10,
    THW_S_EVAL = 2'b11
  } thw_state_e;
  // One agent's relative reading: whole degrees and half degree
  typedef struct packed {
    logic [7:0] deg;
    logic       half;
  } thw_temp_s;
endpackage

// ===== logic/thw_poller.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "thw_regs.svh"
module thw_poller
  import thw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Thermal wire, open drain
  input  wire logic        wire_i,
  output logic             wire_o,
  output logic             wire_oe_o,
  // Interrupt
  output logic             irq_o
);
  logic [7:0]  ensel_reg, dcnt_reg, ctrl_reg, src1_reg, src2_reg, sts_reg, msk_reg;
  logic [7:0]  base_reg [4];
  thw_temp_s   rel_reg [8];
  logic [1:0]  bad_reg [4];
  logic [3:0]  warn_reg;
  thw_state_e  st_reg;
  logic [1:0]  cur_reg, step_reg, q_reg, byte_reg;
  logic [2:0]  bit_reg;
  logic        rd_reg, ok_reg, sy1_reg, sy2_reg, tick, wb_req, wb_wr;
  logic [12:0] div_reg, qtr_len;
  logic [3:0]  gap_reg;
  logic [7:0]  sh_reg, crc_reg, lo_reg, hi_reg, out_byte, idx;
  logic [1:0]  n_out, n_in, nb_idx, nxt_agent;

  assign idx    = wb_adr_i[9:2];
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wire_o = 1'b0; // Open drain: only ever pulls low

  // Quarter-bit length from the speed field
  always_comb
  begin
    unique case (ctrl_reg[1:0])
      2'b00: qtr_len = 13'(`THW_QTR(`THW_KBPS_0));
      2'b01: qtr_len = 13'(`THW_QTR(`THW_KBPS_1));
      2'b10: qtr_len = 13'(`THW_QTR(`THW_KBPS_2));
      2'b11: qtr_len = 13'(`THW_QTR(`THW_KBPS_3));
    endcase
  end

  // Quarter-bit tick divider
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      div_reg <= 13'h0000;
    else
      div_reg <= div_reg + 13'h0001;
  end
  assign tick = (div_reg >= qtr_len - 13'h0001);

  // Two-flop synchroniser on the wire
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sy1_reg <= 1'b1;
      sy2_reg <= 1'b1;
    end
    else
    begin
      sy1_reg <= wire_i;
      sy2_reg <= sy1_reg;
    end
  end

  // Byte to load next: the first one in LOAD, the following one while a byte goes out
  assign nb_idx    = (st_reg == THW_S_XFER) ? byte_reg + 2'h1 : 2'h0;
  assign nxt_agent = cur_reg + 2'h1; // Wraps from agent 3 back to agent 0

  // Frame layout: probe sends address and two zero lengths, then reads a check byte;
  // a query sends address, lengths and command, then reads two bytes and a check byte
  always_comb
  begin
    n_out = (step_reg == 2'h0) ? 2'h2 : 2'h3; // Last byte index
    n_in  = (step_reg == 2'h0) ? 2'h0 : 2'h2; // Index of the received check byte
    unique case (nb_idx)
      2'h0: out_byte = `THW_ADDR_BASE + {6'h00, cur_reg};
      2'h1: out_byte = (step_reg == 2'h0) ? 8'h00 : `THW_WLEN_QUERY;
      2'h2: out_byte = (step_reg == 2'h0) ? 8'h00 : `THW_RLEN_QUERY;
      2'h3: out_byte = `THW_CMD_TEMP + {7'h00, step_reg[1]}; // Domain in command
    endcase
  end

  // Drive low for the first quarter of every bit, and through quarter 2 for a written 0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wire_oe_o <= 1'b0;
    else if (st_reg == THW_S_XFER)
      wire_oe_o <= (q_reg == 2'h0) | (!rd_reg & !sh_reg[7] & (q_reg != 2'h3));
    else
      wire_oe_o <= 1'b0;
  end

  // Poll sequencer and bit engine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg   <= THW_S_IDLE;
      cur_reg  <= 2'h0;
      step_reg <= 2'h0;
      q_reg    <= 2'h0;
      bit_reg  <= 3'h0;
      byte_reg <= 2'h0;
      rd_reg   <= 1'b0;
      sh_reg   <= 8'h00;
      crc_reg  <= 8'h00;
      lo_reg   <= 8'h00;
      hi_reg   <= 8'h00;
      gap_reg  <= 4'h0;
      ok_reg   <= 1'b0;
    end
    else
    begin
      unique case (st_reg)
        THW_S_IDLE:
        begin
          // Idle gap, then next enabled agent in round-robin order
          if (tick)
            gap_reg <= (gap_reg == `THW_GAP_QTRS) ? gap_reg : gap_reg + 4'h1;
          if (gap_reg == `THW_GAP_QTRS)
          begin
            gap_reg <= 4'h0;
            cur_reg <= nxt_agent;
            if (ensel_reg[{1'b1, nxt_agent}])
            begin
              step_reg <= 2'h0;
              st_reg   <= THW_S_LOAD;
            end
          end
        end
        THW_S_LOAD:
        begin
          byte_reg <= 2'h0;
          bit_reg  <= 3'h0;
          q_reg    <= 2'h0;
          rd_reg   <= 1'b0;
          crc_reg  <= 8'h00;
          sh_reg   <= out_byte;
          if (tick)
            st_reg <= THW_S_XFER;
        end
        THW_S_XFER:
        begin
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (rd_reg && q_reg == 2'h1)
              sh_reg[0] <= sy2_reg; // Sample mid-bit
            if (q_reg == 2'h3)
            begin
              // Check covers every bit except the received check byte
              if (!(rd_reg && byte_reg == n_in))
                crc_reg <= {crc_reg[6:0], 1'b0}
                           ^ ((crc_reg[7] ^ sh_reg[rd_reg ? 0 : 7]) ? `THW_CRC_POLY : 8'h00);
              bit_reg <= bit_reg + 3'h1;
              sh_reg  <= rd_reg ? sh_reg : {sh_reg[6:0], 1'b0};
              if (rd_reg && bit_reg != 3'h7)
                sh_reg <= {sh_reg[6:0], 1'b0};
              if (bit_reg == 3'h7)
              begin
                byte_reg <= byte_reg + 2'h1;
                if (!rd_reg && byte_reg == n_out)
                begin
                  rd_reg   <= 1'b1;
                  byte_reg <= 2'h0;
                end
                else if (!rd_reg)
                  sh_reg <= out_byte;
                else if (byte_reg == 2'h0 && n_in != 2'h0)
                  lo_reg <= sh_reg;
                else if (byte_reg == 2'h1)
                  hi_reg <= sh_reg;
                if (rd_reg && byte_reg == n_in)
                begin
                  ok_reg <= (sh_reg == crc_reg);
                  st_reg <= THW_S_EVAL;
                end
              end
            end
          end
        end
        THW_S_EVAL:
        begin
          // Probe first, then domain 0, then domain 1 if counted
          if (step_reg == 2'h0 && ok_reg)
          begin
            step_reg <= 2'h1;
            st_reg   <= THW_S_LOAD;
          end
          else if (step_reg == 2'h1 && dcnt_reg[4 + 32'(cur_reg)])
          begin
            step_reg <= 2'h2;
            st_reg   <= THW_S_LOAD;
          end
          else
            st_reg <= THW_S_IDLE;
        end
      endcase
    end
  end

  // Readings, check failure counts and warnings
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      warn_reg <= 4'h0;
      for (int i = 0; i < 4; i++)
        bad_reg[i] <= 2'h0;
      for (int i = 0; i < 8; i++)
        rel_reg[i] <= '0;
    end
    else if (st_reg == THW_S_EVAL)
    begin
      if (step_reg == 2'h0 && !ok_reg)
        warn_reg[cur_reg] <= 1'b1; // Agent not detected
      else if (step_reg != 2'h0 && ok_reg)
      begin
        bad_reg[cur_reg]  <= 2'h0;
        warn_reg[cur_reg] <= 1'b0;
        rel_reg[{cur_reg, step_reg[1]}] <= '{deg: {hi_reg[5:0], lo_reg[7:6]}, half: lo_reg[5]};
      end
      else if (step_reg != 2'h0)
      begin
        if (bad_reg[cur_reg] != `THW_BAD_LIMIT)
          bad_reg[cur_reg] <= bad_reg[cur_reg] + 2'h1;
        if (bad_reg[cur_reg] >= `THW_BAD_LIMIT - 2'h1)
          warn_reg[cur_reg] <= 1'b1;
      end
    end
  end

  // Per-agent result: select or merge domains, then add base temperature
  thw_temp_s res [4];
  thw_temp_s abs_t [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_agent
      thw_temp_s d0, d1;
      assign d0 = rel_reg[2 * g];
      assign d1 = rel_reg[2 * g + 1];
      assign res[g] = (dcnt_reg[4 + g] && dcnt_reg[`THW_DCNT_MAX_BIT])
                    ? (($signed(d1) > $signed(d0)) ? d1 : d0)
                    : (ensel_reg[g] ? d1 : d0);
      assign abs_t[g] = '{deg: base_reg[g] + res[g].deg, half: res[g].half};
    end
  endgenerate

  // Reading pair source: codes 0..3 name an agent, others read zero
  function automatic thw_temp_s pick(input logic [2:0] s, input thw_temp_s a [4]);
    pick = s[2] ? '0 : a[s[1:0]];
  endfunction
  thw_temp_s rd1, rd2;
  assign rd1 = pick(src1_reg[2:0], abs_t);
  assign rd2 = pick(src2_reg[2:0], abs_t);

  // Wishbone: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req & !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (ctrl_reg[`THW_CTRL_RAW_BIT] && idx >= `THW_IDX_ENSEL && idx <= `THW_IDX_RAWLAST)
        wb_dat_o[7:0] <= rel_reg[3'(idx - `THW_IDX_ENSEL)].deg;
      else if (idx >= `THW_IDX_BASE0 && idx <= `THW_IDX_BASE3)
        wb_dat_o[7:0] <= base_reg[2'(idx - `THW_IDX_BASE0)];
      else
        unique case (idx)
          `THW_IDX_ENSEL:   wb_dat_o[7:0] <= ensel_reg;
          `THW_IDX_DCNT:    wb_dat_o[7:0] <= dcnt_reg;
          `THW_IDX_CTRL:    wb_dat_o[7:0] <= {warn_reg, ctrl_reg[3:0]};
          `THW_IDX_SRC1:    wb_dat_o[7:0] <= src1_reg;
          `THW_IDX_SRC2:    wb_dat_o[7:0] <= src2_reg;
          `THW_IDX_RD1_INT: wb_dat_o[7:0] <= rd1.deg;
          `THW_IDX_RD1_FRC: wb_dat_o[7:0] <= {rd1.half, 7'h00};
          `THW_IDX_RD2_INT: wb_dat_o[7:0] <= rd2.deg;
          `THW_IDX_RD2_FRC: wb_dat_o[7:0] <= {rd2.half, 7'h00};
          `THW_IDX_IRQ_STS: wb_dat_o[7:0] <= sts_reg;
          `THW_IDX_IRQ_MSK: wb_dat_o[7:0] <= msk_reg;
          default:          wb_dat_o[7:0] <= 8'h00;
        endcase
    end
  end

  // Configuration writes; raw mode locks E0h..E7h
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ensel_reg <= `THW_RST_BYTE;
      dcnt_reg  <= `THW_RST_BYTE;
      ctrl_reg  <= `THW_RST_CTRL;
      src1_reg  <= `THW_RST_BYTE;
      src2_reg  <= `THW_RST_BYTE;
      msk_reg   <= `THW_RST_BYTE;
      for (int i = 0; i < 4; i++)
        base_reg[i] <= `THW_RST_BYTE;
    end
    else if (wb_wr)
    begin
      if (!ctrl_reg[`THW_CTRL_RAW_BIT])
      begin
        if (idx == `THW_IDX_ENSEL)
          ensel_reg <= wb_dat_i[7:0];
        if (idx == `THW_IDX_DCNT)
          dcnt_reg <= wb_dat_i[7:0];
        if (idx >= `THW_IDX_BASE0 && idx <= `THW_IDX_BASE3)
          base_reg[2'(idx - `THW_IDX_BASE0)] <= wb_dat_i[7:0];
      end
      if (idx == `THW_IDX_CTRL)
        ctrl_reg <= {4'h0, wb_dat_i[3:0]};
      if (idx == `THW_IDX_SRC1)
        src1_reg <= {5'h00, wb_dat_i[2:0]};
      if (idx == `THW_IDX_SRC2)
        src2_reg <= {5'h00, wb_dat_i[2:0]};
      if (idx == `THW_IDX_IRQ_MSK)
        msk_reg <= {4'h0, wb_dat_i[3:0]};
    end
  end

  // Interrupt status: warning rise sets, write one clears, set wins
  logic [3:0] warn_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      warn_q  <= 4'h0;
      sts_reg <= 8'h00;
    end
    else
    begin
      warn_q  <= warn_reg;
      sts_reg <= {4'h0, (sts_reg[3:0] & ~((wb_wr && idx == `THW_IDX_IRQ_STS) ? wb_dat_i[3:0]
                 : 4'h0)) | (warn_reg & ~warn_q)};
    end
  end
  assign irq_o = |(sts_reg & msk_reg);

  // Checks
  logic [12:0] since_tick;
  logic        rst_q;
  always_ff @(posedge clk_i)
  begin
    since_tick <= (rst_i || tick) ? 13'h0000 : since_tick + 13'h0001;
    rst_q      <= rst_i;
  end
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && $stable(ctrl_reg[1:0]) && !$past(rst_i) |-> since_tick == qtr_len - 13'h0001)
    else $error("tick spacing wrong");
  a_reset_disabled: assert property (@(posedge clk_i)
    rst_q && !rst_i |-> ensel_reg[7:4] == 4'h0) else $error("agents enabled after reset");
  a_only_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == THW_S_IDLE ##1 st_reg == THW_S_LOAD
    |-> |((4'h1 << cur_reg) & $past(ensel_reg[7:4])))
    else $error("disabled agent accessed");
  a_dom1_counted: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == THW_S_LOAD && step_reg == 2'h2 |-> dcnt_reg[4 + 32'(cur_reg)])
    else $error("domain 1 queried without count bit");
  a_raw_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && ctrl_reg[3] |=> $stable(ensel_reg) && $stable(dcnt_reg))
    else $error("write in raw mode took effect");
  a_warn_missing: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == THW_S_EVAL && step_reg == 2'h0 && !ok_reg |=> warn_reg[$past(cur_reg)])
    else $error("missing agent not flagged");
  a_warn_third: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == THW_S_EVAL && step_reg != 2'h0 && !ok_reg && bad_reg[cur_reg] == 2'h2
    |=> warn_reg[$past(cur_reg)]) else $error("third bad check not flagged");
  a_one_agent: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg != THW_S_IDLE && $past(st_reg) != THW_S_IDLE |-> $stable(cur_reg))
    else $error("agent changed mid transaction");
  a_query_after_probe: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == THW_S_EVAL && step_reg == 2'h0 && ok_reg |=> st_reg == THW_S_LOAD
    && step_reg == 2'h1) else $error("query did not follow probe");
  c_probe_ok: cover property (@(posedge clk_i) st_reg == THW_S_EVAL && ok_reg && step_reg == 2'h0);
  c_dom1: cover property (@(posedge clk_i) st_reg == THW_S_EVAL && ok_reg && step_reg == 2'h2);
  c_irq: cover property (@(posedge clk_i) irq_o);
  c_bad_third: cover property (@(posedge clk_i) st_reg == THW_S_EVAL && step_reg != 2'h0
    && !ok_reg && bad_reg[cur_reg] == 2'h2);
endmodule

// ===== tb/thw_client_model.sv
`timescale 1ns/1ns
`include "thw_regs.svh"
// Behavioural client on the thermal wire: decodes host bits, answers probes and queries
module thw_client_model
  import thw_pkg::*;
#(
  parameter int QTR = 5
)
(
  // Clock and resolved line
  input  wire logic        clk_i,
  input  wire logic        wire_i,
  // Settings from the bench
  input  wire logic [3:0]  present_i,
  input  wire logic [3:0]  bad_i,
  input  wire logic [15:0] temp_i [0:7],
  // Client pull and probe report
  output logic             pull_o,
  output logic             probe_o,
  output logic [1:0]       probe_agent_o
);
  logic        prev    = 1'b1;
  logic        reading = 1'b0;
  logic        wbit    = 1'b0;
  logic        act     = 1'b0;
  logic        pr      = 1'b0;
  logic [31:0] wsh     = '0;
  logic [23:0] rsh     = '0;
  logic [7:0]  crc;
  logic [15:0] t;
  int          low_cnt  = 0;
  int          high_cnt = 0;
  int          pull_cnt = 0;
  int          nbits    = 0;
  int          rbits    = 0;

  // Check byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[7] ^ b[i]) ? ({r[6:0], 1'b0} ^ `THW_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // Line released at time zero
  initial
  begin
    pull_o = 1'b0;
    probe_o = 1'b0;
    probe_agent_o = 2'h0;
  end

  // Low phase length tells a written one from a zero; zeros answered by stretching
  always @(posedge clk_i)
  begin
    pr = 1'b0;
    if (pull_cnt != 0)
      pull_cnt = pull_cnt - 1;
    if (wire_i)
    begin
      high_cnt = high_cnt + 1;
      if (high_cnt > 6 * QTR)
      begin
        nbits = 0;
        reading = 1'b0;
      end
    end
    else
    begin
      high_cnt = 0;
      low_cnt = low_cnt + 1;
    end
    if (prev && !wire_i)
    begin
      low_cnt = 1;
      wbit = !reading;
      if (reading)
      begin
        if (act && !rsh[23])
          pull_cnt = 3 * QTR;
        rsh = {rsh[22:0], 1'b0};
        rbits = rbits - 1;
        if (rbits == 0)
        begin
          reading = 1'b0;
          nbits = 0;
        end
      end
    end
    if (!prev && wire_i && wbit)
    begin
      wsh = {wsh[30:0], low_cnt <= 2 * QTR};
      nbits = nbits + 1;
      if (nbits == 24 && wsh[15:8] == 8'h00)
      begin
        act = present_i[wsh[17:16]];
        crc = crc8(crc8(crc8(8'h00, wsh[23:16]), wsh[15:8]), wsh[7:0]);
        rsh = {crc, 16'h0000}; // Probes stay good so bad checks hit queries only
        rbits = 8;
        reading = 1'b1;
        pr = 1'b1;
        probe_agent_o <= wsh[17:16];
      end
      if (nbits == 32)
      begin
        act = present_i[wsh[25:24]];
        t = temp_i[{wsh[25:24], wsh[1]}];
        crc = crc8(crc8(crc8(crc8(8'h00, wsh[31:24]), wsh[23:16]), wsh[15:8]), wsh[7:0]);
        crc = crc8(crc8(crc, t[7:0]), t[15:8]);
        rsh = {t[7:0], t[15:8], crc ^ {8{bad_i[wsh[25:24]]}}};
        rbits = 24;
        reading = 1'b1;
      end
    end
    pull_o <= (pull_cnt != 0);
    probe_o <= pr;
    prev = wire_i;
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "thw_regs.svh"
// Bench for the thermal wire poller
module tb
  import thw_pkg::*;
;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [9:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wire_o;
  logic        wire_oe_o;
  logic        irq_o;
  logic        wire_lvl;
  logic        pull;
  logic        probe;
  logic [1:0]  probe_agent;
  logic [1:0]  last_agent = 2'h0;
  logic [3:0]  present    = 4'hF;
  logic [3:0]  bad        = 4'h0;
  logic [3:0]  en_shadow  = 4'h0;
  logic [3:0]  en_prev    = 4'h0;
  logic [15:0] temp [0:7];
  int          guard      = 0;
  int          n_mismatch = 0;
  int          checks     = 0;

  // 20 MHz clock; pulled-up line low when either side pulls
  always #25 clk_i = ~clk_i;
  assign wire_lvl = !(wire_oe_o === 1'b1 && wire_o === 1'b0) && !pull;

  thw_poller dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wire_i(wire_lvl), .wire_o(wire_o),
    .wire_oe_o(wire_oe_o), .irq_o(irq_o));
  thw_client_model #(.QTR(5)) client_u (.clk_i(clk_i), .wire_i(wire_lvl), .present_i(present),
    .bad_i(bad), .temp_i(temp), .pull_o(pull), .probe_o(probe), .probe_agent_o(probe_agent));

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                         output logic [7:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      n = n + 1;
      if (n > 20)
      begin
        n_mismatch++;
        $display("FAIL wb_ack_o expected 1 seen %b", wb_ack_o);
        test_done();
      end
      @(posedge clk_i);
    end
    rdat = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    wb_xfer(1'b1, idx, d, unused);
    if (idx == `THW_IDX_ENSEL)
      en_shadow = d[7:4];
  endtask

  // Read until the value appears or the tries run out
  task automatic rd_expect(input logic [7:0] idx, input logic [7:0] exp, input int tries);
    logic [7:0] got;
    int k;
    k = 0;
    wb_xfer(1'b0, idx, 8'h00, got);
    while (got !== exp && k < tries)
    begin
      repeat (50) @(posedge clk_i);
      wb_xfer(1'b0, idx, 8'h00, got);
      k++;
    end
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL reg %h expected %h seen %h", idx, exp, got);
    end
  endtask

  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk_i);
    checks++;
    if (irq_o !== exp)
    begin
      n_mismatch++;
      $display("FAIL irq_o expected %b seen %b", exp, irq_o);
    end
  endtask

  task automatic test_end(input string nm);
    $display("test %s done, mismatches %0d", nm, n_mismatch);
  endtask

  // Wire monitor: quiet while all agents off, probes only to enabled agents in turn
  always @(posedge clk_i)
  begin
    en_prev <= en_shadow;
    if (en_prev != en_shadow)
      guard <= 4000;
    else if (guard > 0)
      guard <= guard - 1;
    if (probe && guard == 0)
    begin
      checks++;
      if (!en_shadow[probe_agent] || ($countones(en_shadow) > 1 && probe_agent == last_agent))
      begin
        n_mismatch++;
        $display("FAIL probe agent expected next enabled seen %0d", probe_agent);
      end
    end
    if (probe)
      last_agent <= probe_agent;
    if (!rst_i && en_shadow == 4'h0 && wire_oe_o === 1'b1)
    begin
      n_mismatch++;
      $display("FAIL wire_oe_o expected 0 seen 1");
    end
  end

  // Main sequence
  initial
  begin
    for (int i = 0; i < 8; i++)
      temp[i] = 16'h0000;
    temp[0] = 16'hFDA0;
    temp[2] = 16'h0280;
    temp[3] = 16'h0140;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_expect(`THW_IDX_ENSEL, 8'h00, 0);
    rd_expect(`THW_IDX_DCNT, 8'h00, 0);
    rd_expect(`THW_IDX_CTRL, 8'h03, 0);
    rd_expect(8'h10, 8'h00, 0);
    wr(`THW_IDX_CTRL, 8'h02);
    rd_expect(`THW_IDX_CTRL, 8'h02, 0);
    wr(`THW_IDX_CTRL, 8'h03);
    chk_irq(1'b0);
    repeat (2000) @(posedge clk_i);
    test_end("reset");
    wr(`THW_IDX_BASE0, 8'h48);
    wr(8'hE2, 8'h20);
    wr(`THW_IDX_SRC1, 8'h00);
    wr(`THW_IDX_SRC2, 8'h01);
    wr(`THW_IDX_ENSEL, 8'h30);
    rd_expect(`THW_IDX_RD1_INT, 8'h3E, 300);
    rd_expect(`THW_IDX_RD1_FRC, 8'h80, 0);
    rd_expect(`THW_IDX_RD2_INT, 8'h2A, 300);
    rd_expect(`THW_IDX_RD2_FRC, 8'h00, 0);
    test_end("readings");
    wr(`THW_IDX_DCNT, 8'h20);
    wr(`THW_IDX_ENSEL, 8'h32);
    rd_expect(`THW_IDX_RD2_INT, 8'h25, 300);
    wr(`THW_IDX_DCNT, 8'h22);
    rd_expect(`THW_IDX_RD2_INT, 8'h2A, 300);
    wr(`THW_IDX_SRC1, 8'h04);
    rd_expect(`THW_IDX_RD1_INT, 8'h00, 300);
    test_end("domains");
    wr(`THW_IDX_CTRL, 8'h0B);
    rd_expect(`THW_IDX_ENSEL, 8'hF6, 0);
    rd_expect(8'hE2, 8'h0A, 0);
    rd_expect(8'hE3, 8'h05, 0);
    wr(`THW_IDX_BASE0, 8'h11);
    wr(`THW_IDX_CTRL, 8'h03);
    rd_expect(`THW_IDX_BASE0, 8'h48, 0);
    test_end("raw");
    wr(`THW_IDX_IRQ_MSK, 8'h0F);
    present <= 4'hB;
    wr(`THW_IDX_ENSEL, 8'h72);
    rd_expect(`THW_IDX_CTRL, 8'h43, 300);
    rd_expect(`THW_IDX_IRQ_STS, 8'h04, 0);
    chk_irq(1'b1);
    wr(`THW_IDX_IRQ_MSK, 8'h0B);
    chk_irq(1'b0);
    wr(`THW_IDX_IRQ_MSK, 8'h0F);
    chk_irq(1'b1);
    wr(`THW_IDX_IRQ_STS, 8'h04);
    rd_expect(`THW_IDX_IRQ_STS, 8'h00, 0);
    chk_irq(1'b0);
    wr(`THW_IDX_ENSEL, 8'h32);
    bad <= 4'h1;
    rd_expect(`THW_IDX_CTRL, 8'h53, 600);
    rd_expect(`THW_IDX_IRQ_STS, 8'h01, 0);
    chk_irq(1'b1);
    bad <= 4'h0;
    rd_expect(`THW_IDX_CTRL, 8'h43, 300);
    test_end("warnings");
    test_done();
  end
endmodule
